// >>> design/motion_event_engines.sv
// Purpose: Orientation, wake-up motion and tap detection engines
// Assumes: Samples arrive with a one-cycle sample_valid at the data rate
// Notes:   Settings are used live; hold operating_enable low to change them
`timescale 1ns/1ps
module motion_event_engines
	import motion_event_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       operating_enable,
	input  wire logic       sample_valid,
	input  wire accel_t     accel,
	input  wire accel_t     hpf,
	input  wire jerk_t      jerk,
	input  wire logic [7:0] tilt_angle,
	input  wire logic [7:0] orient_debounce_count,
	input  wire logic [7:0] wake_motion_threshold,
	input  wire logic [7:0] wake_debounce_count,
	input  wire logic [7:0] wake_sample_rate,
	input  wire logic       wake_latched,
	input  wire logic       wake_ack,
	input  wire tap_cfg_t   tap_cfg,
	output logic [5:0]      orientation_q,
	output logic            orient_change_q,
	output logic            wake_active_q,
	output logic            wake_detect_q,
	output logic            wake_end_q,
	output logic            tap_single_q,
	output logic            tap_double_q,
	output logic [2:0]      tap_axis_q,
	output logic            tap_neg_q
);

	// Magnitude of a signed sample; -128 maps to 128 unsigned
	function automatic logic [7:0] mag(input logic signed [7:0] a);
		mag = a[7] ? 8'(-a) : 8'(a);
	endfunction : mag

	// ----------------------------------------------------------------
	// Orientation candidate
	// ----------------------------------------------------------------
	// Settings are not shadowed; the host parks the engine first
	wire       clear    = !operating_enable;
	wire       ori_step = sample_valid && operating_enable;
	wire [7:0] ax       = mag(accel.x);
	wire [7:0] ay       = mag(accel.y);
	wire       tilted   = (ax > tilt_angle) || (ay > tilt_angle);
	wire [5:0] face_c   = accel.z[7] ? ORI_FACE_DOWN : ORI_FACE_UP;
	wire [5:0] rotx_c   = accel.x[7] ? ORI_ROT_270 : ORI_ROT_90;
	wire [5:0] roty_c   = accel.y[7] ? ORI_ROT_180 : ORI_ROT_0;
	wire [5:0] rot_c    = (ax > ay) ? rotx_c : roty_c;
	wire [5:0] ori_cand = tilted ? rot_c : face_c;

	event_debounce #(
		.W         (ORI_W),
		.RST_STATE (ORI_FACE_UP)
	) u_ori_deb (
		.clk       (clk),
		.arst_n    (arst_n),
		.clear     (clear),
		.step      (ori_step),
		.cand      (ori_cand),
		.limit     (orient_debounce_count),
		.state_q   (orientation_q),
		.changed_q (orient_change_q)
	);

	// ----------------------------------------------------------------
	// Wake-up motion
	// ----------------------------------------------------------------
	// Wake period is a divided sample strobe so one count is one period
	logic [7:0] wdiv_q;
	logic       wake_chg;
	wire        wdiv_hit  = wdiv_q >= wake_sample_rate;
	wire        wake_step = ori_step && wdiv_hit;
	wire        wake_cand = (mag(hpf.x) > wake_motion_threshold)
	                     || (mag(hpf.y) > wake_motion_threshold)
	                     || (mag(hpf.z) > wake_motion_threshold);
	wire        wake_rise = wake_chg && wake_active_q;
	wire        wake_fall = wake_chg && !wake_active_q;

	// Wake rate divider
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wdiv_q <= CNT_ZERO;
		end else if (clear || wake_step) begin
			wdiv_q <= CNT_ZERO;
		end else if (ori_step) begin
			wdiv_q <= wdiv_q + CNT_ONE;
		end
	end

	event_debounce #(
		.W         (1),
		.RST_STATE (WAKE_RST)
	) u_wake_deb (
		.clk       (clk),
		.arst_n    (arst_n),
		.clear     (clear),
		.step      (wake_step),
		.cand      (wake_cand),
		.limit     (wake_debounce_count),
		.state_q   (wake_active_q),
		.changed_q (wake_chg)
	);

	// Indication: latched holds until ack, and a new rise beats the ack
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_detect_q <= 1'b0;
			wake_end_q    <= 1'b0;
		end else if (!wake_latched) begin
			wake_detect_q <= wake_active_q;
			wake_end_q    <= wake_fall;
		end else begin
			wake_detect_q <= wake_rise || (wake_detect_q && !wake_ack);
			wake_end_q    <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Tap detection
	// ----------------------------------------------------------------
	tap_state_t tap_st_q;
	tap_state_t tap_st_d;
	logic [7:0] tmr_q;
	logic [7:0] tmr_d;
	logic [7:0] dur_q;
	logic [7:0] dur_d;
	jerk_t      cap_q;
	logic       cap_en;
	logic       rep_single;
	logic       rep_double;

	// Over-range samples neither extend nor end a pulse
	wire       over    = jerk.sum > tap_cfg.high;
	wire       above   = (jerk.sum > tap_cfg.low) && !over;
	wire       below   = jerk.sum <= tap_cfg.low;
	wire [7:0] tmr_n   = (tmr_q == CNT_MAX) ? CNT_MAX : tmr_q + CNT_ONE;
	wire [7:0] dur_n   = (dur_q == CNT_MAX) ? CNT_MAX : dur_q + CNT_ONE;
	wire       dur_ok  = (dur_q > tap_cfg.dur_min)
	                  && (dur_q < tap_cfg.dur_max);
	wire       too_long = dur_n >= tap_cfg.dur_max;
	wire       lat_end = tmr_n >= tap_cfg.latency;
	wire       win_end = tmr_n >= tap_cfg.window;
	wire       gap_ok  = tmr_q >= tap_cfg.gap;

	// Next state, evaluated once per sample
	always_comb begin
		tap_st_d   = tap_st_q;
		tmr_d      = tmr_q;
		dur_d      = dur_q;
		cap_en     = 1'b0;
		rep_single = 1'b0;
		rep_double = 1'b0;
		if (ori_step) begin
			case (tap_st_q)
				TAP_IDLE: begin
					if (above) begin
						tap_st_d = TAP_FIRST;
						dur_d    = CNT_ONE;
					end
				end
				TAP_FIRST: begin
					if (above) begin
						dur_d    = dur_n;
						tap_st_d = too_long ? TAP_IDLE : TAP_FIRST;
					end else if (below) begin
						tap_st_d = dur_ok ? TAP_LAT1 : TAP_IDLE;
						tmr_d    = CNT_ZERO;
						cap_en   = dur_ok;
					end
				end
				TAP_LAT1: begin
					tmr_d = tmr_n; // Taps here are dropped
					if (lat_end) begin
						tap_st_d = TAP_WIN;
					end
				end
				TAP_WIN: begin
					tmr_d = tmr_n;
					if (win_end) begin
						tap_st_d   = TAP_IDLE;
						rep_single = 1'b1;
					end else if (above && gap_ok) begin
						tap_st_d = TAP_SECOND;
						dur_d    = CNT_ONE;
					end
				end
				TAP_SECOND: begin
					tmr_d = tmr_n;
					if (above) begin
						dur_d    = dur_n;
						tap_st_d = too_long ? TAP_WIN : TAP_SECOND;
					end else if (below) begin
						tap_st_d = dur_ok ? TAP_LAT2 : TAP_WIN;
						tmr_d    = dur_ok ? CNT_ZERO : tmr_n;
						cap_en   = dur_ok;
					end
				end
				TAP_LAT2: begin
					tmr_d = tmr_n;
					if (lat_end) begin
						tap_st_d   = TAP_IDLE;
						rep_double = 1'b1;
					end
				end
				default: begin
					tap_st_d = TAP_IDLE;
				end
			endcase
		end
	end

	// Tap state and timers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tap_st_q <= TAP_IDLE;
			tmr_q    <= CNT_ZERO;
			dur_q    <= CNT_ZERO;
			cap_q    <= '0;
		end else if (clear) begin
			tap_st_q <= TAP_IDLE;
			tmr_q    <= CNT_ZERO;
			dur_q    <= CNT_ZERO;
		end else begin
			tap_st_q <= tap_st_d;
			tmr_q    <= tmr_d;
			dur_q    <= dur_d;
			if (cap_en) begin
				cap_q <= jerk; // Axis and polarity of the below-low sample that ends the tap
			end
		end
	end

	// Tap report: pulses plus axis and polarity held until the next one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tap_single_q <= 1'b0;
			tap_double_q <= 1'b0;
			tap_axis_q   <= AXIS_NONE;
			tap_neg_q    <= 1'b0;
		end else begin
			tap_single_q <= rep_single && !clear;
			tap_double_q <= rep_double && !clear;
			if ((rep_single || rep_double) && !clear) begin
				tap_axis_q <= cap_q.axis;
				tap_neg_q  <= cap_q.neg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_second_done;
		(tap_st_q == TAP_SECOND) ##1 (tap_st_q == TAP_LAT2);
	endsequence

	sequence s_enter_second;
		(tap_st_q == TAP_WIN) ##1 (tap_st_q == TAP_SECOND);
	endsequence

	AST_FACE_SIGN: assert property (
		$rose(orientation_q == ORI_FACE_DOWN) |-> $past(accel.z[7]))
		else $error("Face-down reported without negative z");

	AST_TILT_GATE: assert property (
		($changed(orientation_q) && |(orientation_q & ORI_ROT_MASK))
		|-> $past(tilted))
		else $error("Rotation state entered below tilt limit");

	AST_ORI_QUAL: assert property (
		$changed(orientation_q)
		|-> ($past(ori_cand) == orientation_q) && $past(ori_step))
		else $error("Orientation changed off a sample or candidate");

	AST_WAKE_RISE: assert property (
		$rose(wake_active_q) |-> $past(wake_cand) && $past(wake_step))
		else $error("Wake active without axis above threshold");

	AST_WAKE_END: assert property (
		($fell(wake_active_q) && !wake_latched) |=> wake_end_q)
		else $error("Unlatched motion end not reported");

	AST_WAKE_PERIOD: assert property (
		(wake_step && wake_sample_rate != CNT_ZERO)
		|=> !wake_step [*1])
		else $error("Wake period shorter than divider");

	AST_TAP_DUR: assert property (
		s_second_done
		|-> ($past(dur_q) > tap_cfg.dur_min)
		 && ($past(dur_q) < tap_cfg.dur_max))
		else $error("Second tap outside duration limits");

	AST_LAT_IGNORE: assert property (
		(tap_st_q == TAP_LAT1 && operating_enable)
		|=> (tap_st_q == TAP_LAT1) || (tap_st_q == TAP_WIN))
		else $error("Tap accepted inside latency period");

	AST_GAP: assert property (
		s_enter_second |-> $past(tmr_q) >= $past(tap_cfg.gap))
		else $error("Second tap accepted before minimum gap");

	AST_DOUBLE_AT_LAT: assert property (
		tap_double_q |-> $past(tap_st_q) == TAP_LAT2)
		else $error("Double tap reported outside second latency");

	AST_SINGLE_AT_WIN: assert property (
		tap_single_q |-> $past(tap_st_q) == TAP_WIN ##0 $past(win_end))
		else $error("Single tap reported before window end");

	AST_LATCH_HOLD: assert property (
		(wake_latched && wake_detect_q && !wake_ack) |=> wake_detect_q)
		else $error("Latched wake indication dropped without ack");

endmodule : motion_event_engines

// >>> shared/motion_event_pkg.sv
// Purpose: Shared constants and carrier types for the motion event engines
// Assumes: 8-bit signed samples scaled at 32 counts per g for orientation
// Notes:   One-hot codes are used for orientation, tap axis and tap states
package motion_event_pkg;

	// ----------------------------------------------------------------
	// Widths and scales
	// ----------------------------------------------------------------
	localparam int         ACC_W          = 8;
	localparam int         CNT_W          = 8;
	localparam int         ORI_W          = 6;
	localparam logic [7:0] TILT_SCALE_CPG = 8'h20; // Host scale, counts per g

	// ----------------------------------------------------------------
	// Orientation codes, one-hot
	// ----------------------------------------------------------------
	localparam logic [5:0] ORI_FACE_UP   = 6'h01;
	localparam logic [5:0] ORI_FACE_DOWN = 6'h02;
	localparam logic [5:0] ORI_ROT_0     = 6'h04;
	localparam logic [5:0] ORI_ROT_90    = 6'h08;
	localparam logic [5:0] ORI_ROT_180   = 6'h10;
	localparam logic [5:0] ORI_ROT_270   = 6'h20;
	localparam logic [5:0] ORI_ROT_MASK  = 6'h3c;

	// ----------------------------------------------------------------
	// Tap axis codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] AXIS_NONE   = 3'h0;
	localparam logic [2:0] AXIS_X      = 3'h1;
	localparam logic [2:0] AXIS_Y      = 3'h2;
	localparam logic [2:0] AXIS_Z      = 3'h4;
	localparam logic [7:0] CNT_ZERO    = 8'h00;
	localparam logic [7:0] CNT_ONE     = 8'h01;
	localparam logic [7:0] CNT_MAX     = 8'hff;
	localparam logic       WAKE_RST    = 1'b0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic signed [7:0] x;
		logic signed [7:0] y;
		logic signed [7:0] z;
	} accel_t;

	typedef struct packed {
		logic [7:0] sum;  // Jerk summation magnitude
		logic [2:0] axis; // Dominant axis, one-hot
		logic       neg;  // Polarity of the dominant jerk
	} jerk_t;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] dur_min;
		logic [7:0] dur_max;
		logic [7:0] latency;
		logic [7:0] window;
		logic [7:0] gap;
	} tap_cfg_t;

	typedef enum logic [5:0] {
		TAP_IDLE   = 6'h01,
		TAP_FIRST  = 6'h02,
		TAP_LAT1   = 6'h04,
		TAP_WIN    = 6'h08,
		TAP_SECOND = 6'h10,
		TAP_LAT2   = 6'h20
	} tap_state_t;

endpackage : motion_event_pkg

// >>> design/event_debounce.sv
// Purpose: State qualifier that commits a candidate after a persist count
// Assumes: step is a one-cycle pulse per sample period
// Notes:   A limit of zero or one commits on the first differing sample
`timescale 1ns/1ps
module event_debounce
	import motion_event_pkg::*;
#(
	parameter int             W         = 6,
	parameter logic [W-1:0]   RST_STATE = '0
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic [W-1:0] cand,
	input  wire logic [7:0]   limit,
	output logic [W-1:0]      state_q,
	output logic              changed_q
);

	if (W < 1) begin : g_bad_width
		$error("event_debounce: W must be at least 1");
	end

	logic [W-1:0] pend_q;
	logic [7:0]   cnt_q;

	// ----------------------------------------------------------------
	// Persist counting
	// ----------------------------------------------------------------
	// A new candidate restarts at one so a flicker never inherits counts
	wire       differ   = cand != state_q;
	wire       same_pnd = cand == pend_q;
	wire [7:0] cnt_inc  = (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + CNT_ONE;
	wire [7:0] cnt_n    = same_pnd ? cnt_inc : CNT_ONE;
	wire       reach    = cnt_n >= limit;

	// State, pending candidate and count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= RST_STATE;
			pend_q    <= RST_STATE;
			cnt_q     <= CNT_ZERO;
			changed_q <= 1'b0;
		end else if (clear) begin
			cnt_q     <= CNT_ZERO;
			changed_q <= 1'b0;
		end else begin
			changed_q <= step && differ && reach;
			if (step && differ && reach) begin
				state_q <= cand;
				cnt_q   <= CNT_ZERO;
			end else if (step && differ) begin
				pend_q  <= cand;
				cnt_q   <= cnt_n;
			end else if (step) begin
				cnt_q   <= CNT_ZERO; // Candidate reverted
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	AST_DEB_RESTART: assert property (
		(step && !clear && differ && !same_pnd && !reach)
		|=> (cnt_q == CNT_ONE))
		else $error("Debounce count did not restart on new candidate");

endmodule : event_debounce

// >>> verification/host_model.sv
// Purpose: Host side that programs the event engine settings
// Assumes: Settings are written only while operating_enable is low
// Notes:   Tilt and wake figures are scaled from angle and milli-g
`timescale 1ns/1ps
module host_model
	import motion_event_pkg::*;
(
	input  wire logic  clk,
	output logic       operating_enable,
	output logic [7:0] tilt_angle,
	output logic [7:0] orient_debounce_count,
	output logic [7:0] wake_motion_threshold,
	output logic [7:0] wake_debounce_count,
	output logic [7:0] wake_sample_rate,
	output logic       wake_latched,
	output tap_cfg_t   tap_cfg
);
	// Engines idle until the first setup
	initial begin
		operating_enable = 1'b0;
		tilt_angle = 8'h00;
		orient_debounce_count = 8'h00;
		wake_motion_threshold = 8'h00;
		wake_debounce_count = 8'h00;
		wake_sample_rate = 8'h00;
		wake_latched = 1'b0;
		tap_cfg = '0;
	end

	// Disable first so no engine ever runs on a half-written setting
	task automatic setup(input int deg, odb, wmg, wdb, wrt,
		input logic lat, input tap_cfg_t tc);
		@(posedge clk);
		operating_enable <= 1'b0;
		@(posedge clk);
		tilt_angle <= 8'($rtoi($sin(deg * 3.14159 / 180.0)
			* TILT_SCALE_CPG + 0.5));
		wake_motion_threshold <= 8'(wmg * 32 / 1000);
		orient_debounce_count <= 8'(odb);
		wake_debounce_count <= 8'(wdb);
		wake_sample_rate <= 8'(wrt);
		wake_latched <= lat;
		tap_cfg <= tc;
		@(posedge clk);
		operating_enable <= 1'b1;
	endtask : setup
endmodule : host_model

// >>> verification/motion_event_engines_tb.sv
// Purpose: Self-checking bench for the motion event engines
// Assumes: One sample strobe every second clock
// Notes:   Every event pulse is matched against a queue of notes
`timescale 1ns/1ps
module motion_event_engines_tb
	import motion_event_pkg::*;
;
	logic clk, arst_n, operating_enable, sample_valid, wake_latched;
	logic wake_ack, orient_change_q, wake_active_q, wake_detect_q;
	logic wake_end_q, tap_single_q, tap_double_q, tap_neg_q, det_prev;
	logic [7:0] tilt_angle, orient_debounce_count, wake_motion_threshold;
	logic [7:0] wake_debounce_count, wake_sample_rate;
	logic [5:0] orientation_q, e_ori;
	logic [2:0] tap_axis_q, e_axis;
	logic       e_neg;
	accel_t     accel, hpf;
	jerk_t      jerk;
	tap_cfg_t   tcfg;
	logic [14:0] exp_q[$];
	int         n_mismatch, check_count;
	int         sx[6] = '{-1, 1, 0, 0, 0, 0};
	int         sy[6] = '{0, 0, -1, 1, 0, 0};
	int         sz[6] = '{-1, 0, 0, 0, 1, -1};
	logic [5:0] oc[6] = '{ORI_ROT_270, ORI_ROT_90, ORI_ROT_180, ORI_ROT_0,
		ORI_FACE_UP, ORI_FACE_DOWN};

	wire        rise = wake_detect_q & ~det_prev;
	wire [14:0] ev_w = {orient_change_q, orientation_q, rise, wake_end_q,
		tap_single_q, tap_double_q, tap_axis_q, tap_neg_q};
	wire        hit  = orient_change_q | rise | wake_end_q | tap_single_q
		| tap_double_q;

	motion_event_engines i_motion_event_engines (.clk, .arst_n,
		.operating_enable, .sample_valid, .accel, .hpf, .jerk, .tilt_angle,
		.orient_debounce_count, .wake_motion_threshold, .wake_debounce_count,
		.wake_sample_rate, .wake_latched, .wake_ack, .tap_cfg(tcfg),
		.orientation_q, .orient_change_q, .wake_active_q, .wake_detect_q,
		.wake_end_q, .tap_single_q, .tap_double_q, .tap_axis_q, .tap_neg_q);

	host_model i_host_model (.clk, .operating_enable, .tilt_angle,
		.orient_debounce_count, .wake_motion_threshold, .wake_debounce_count,
		.wake_sample_rate, .wake_latched, .tap_cfg(tcfg));

	// --------------------------------------------------------------
	// Checking
	// --------------------------------------------------------------
	task automatic check(input string what, input logic [14:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic note(input logic c, r, e, s, d);
		exp_q.push_back({c, e_ori, r, e, s, d, e_axis, e_neg});
	endtask : note

	task summarize;
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	// Sampled mid-cycle so registered outputs have settled
	always @(negedge clk) begin
		det_prev <= wake_detect_q;
		if (hit && exp_q.size() == 0)
			check("stray event", ev_w, 15'h0000);
		else if (hit)
			check("event", ev_w, exp_q.pop_front());
	end

	// --------------------------------------------------------------
	// Stimulus
	// --------------------------------------------------------------
	task automatic smp(input accel_t a, h, input jerk_t j);
		@(posedge clk);
		sample_valid <= 1'b1;
		accel <= a;
		hpf <= h;
		jerk <= j;
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask : smp

	task automatic ori(input int x, y, z, n);
		repeat (n) smp('{8'(x), 8'(y), 8'(z)}, '0, '0);
	endtask : ori

	// Device lies face down while wake and tap traffic runs
	task automatic wk(input int v, n);
		repeat (n) smp('{8'h00, 8'h00, 8'he2}, '{8'h00, 8'(v), 8'h00}, '0);
	endtask : wk

	// a/A above low, h above high, b/B below low; capitals on z, positive
	task automatic tp(input string s);
		jerk_t j;
		foreach (s[i]) begin
			j.sum = (s[i] == "h") ? 8'($urandom_range(101, 255)) :
				(s[i] inside {"a", "A"}) ? 8'($urandom_range(21, 100)) :
				8'($urandom_range(0, 20));
			j.axis = (s[i] inside {"A", "B"}) ? AXIS_Z : AXIS_X;
			j.neg = !(s[i] inside {"A", "B"});
			smp('{8'h00, 8'h00, 8'he2}, '0, j);
		end
	endtask : tp

	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Main sequence
	initial begin
		int m;
		void'($urandom(32'h8ed47e38));
		arst_n = 1'b0;
		sample_valid = 1'b0;
		wake_ack = 1'b0;
		accel = '0;
		hpf = '0;
		jerk = '0;
		e_ori = ORI_FACE_UP;
		e_axis = AXIS_NONE;
		e_neg = 1'b0;
		repeat (6) @(posedge clk);
		check("reset", ev_w, {1'b0, ORI_FACE_UP, 8'h00});
		arst_n <= 1'b1;
		i_host_model.setup(30, 2, 1250, 2, 1, 1'b0,
			'{8'h14, 8'h64, 8'h01, 8'h05, 8'h01, 8'h06, 8'h02});
		// Orientation: an early revert must restart the count
		ori(0, 0, -30, 1);
		ori(0, 0, 30, 1);
		ori(0, 0, -30, 1);
		e_ori = ORI_FACE_DOWN;
		note(1, 0, 0, 0, 0);
		ori(0, 0, -30, 1);
		ori(-16, 5, -30, 2);
		m = $urandom_range(17, 100);
		foreach (oc[i]) begin
			e_ori = oc[i];
			note(1, 0, 0, 0, 0);
			ori(sx[i] * m, sy[i] * m, sz[i] * 30, 2);
		end
		// Wake, unlatched: a short burst must not qualify
		wk(40, 4);
		wk(60, 2);
		wk(0, 2);
		note(0, 1, 0, 0, 0);
		wk(-$urandom_range(41, 127), 4);
		@(negedge clk);
		check("active", {14'h0, wake_active_q}, 15'h0001);
		note(0, 0, 1, 0, 0);
		wk(0, 4);
		// Wake, latched: held until acknowledged
		i_host_model.setup(30, 2, 1250, 2, 1, 1'b1, tcfg);
		note(0, 1, 0, 0, 0);
		wk($urandom_range(41, 127), 4);
		wk(0, 6);
		@(negedge clk);
		check("latched", {14'h0, wake_detect_q}, 15'h0001);
		@(posedge clk);
		wake_ack <= 1'b1;
		@(posedge clk);
		wake_ack <= 1'b0;
		repeat (2) @(posedge clk);
		check("acked", {14'h0, wake_detect_q}, 15'h0000);
		// Taps: over-high sample skipped, bad durations dropped
		e_axis = AXIS_X;
		e_neg = 1'b1;
		note(0, 0, 0, 1, 0);
		tp("aaahabbbbbbbbbb");
		tp("aaaaabbbbbbbbbbb");
		tp("abbbbbbbbbbb");
		note(0, 0, 0, 1, 0);
		tp("aabAAAbbbbbbbbbb");
		e_axis = AXIS_Z;
		e_neg = 1'b0;
		note(0, 0, 0, 0, 1);
		tp("aabbbAABBBBBBBBB");
		for (int i = 0; i < 100 && exp_q.size() > 0; i++)
			@(posedge clk);
		if (exp_q.size() > 0) begin
			n_mismatch++;
			$display("[ERR] pending events expected 0 seen %0d", exp_q.size());
		end
		summarize();
	end
endmodule : motion_event_engines_tb
